// File: core/itvu_pkg.sv
// constants, carriers and helper functions of the two-level vectored interrupt unit
//
// Operation
// - both external request pins active low; per-pin bit picks level or falling edge
// - pending flags for the two pins sit at bits 1 and 3 of timer control
// - edge mode: the pin's pending flag clears when its vector call is taken
// - level mode: the pin's pending flag follows the inverted pin every cycle
// - pin zero vectors to 0x0003, order 0, enable bit 0, priority bit 0
// - pin one vectors to 0x0013, order 2, enable bit 2, priority bit 2
// - each source carries a register page, used when automatic page switching is on
// - every source can be set to low or high level on its own
// - one priority bit per source across base and two extended priority registers
// - a high-level request may preempt a running low-level routine
// - nothing preempts a running high-level routine
// - after reset every source sits at the low level
// - among simultaneous requests high level wins over low level
// - within one level the lowest fixed order number wins, 0 through 20
// - pending requests are sampled and decoded on every clock
// - best response: one detection cycle, then a four-cycle vector call
// - pending at return: exactly one more instruction runs before the call
// - worst response without nesting is 18 clocks: 1 + 5 + 8 + 4
// - equal or lower level waits until return plus one instruction complete
// - global enable bit gates every source enable
// - pending flags set whether or not the source is enabled
// - an accepted request calls its vector once the current instruction ends
// - a flag still set after return requests again after the next instruction
package itvu_pkg;

  localparam int           NUM_SRC      = 21;
  localparam int           ORDER_W      = 5;
  localparam int           ADDR_W       = 8;

  // apb byte addresses
  localparam logic [7:0]   OFS_TCTRL    = 8'h00;
  localparam logic [7:0]   OFS_BASE_EN  = 8'h04;
  localparam logic [7:0]   OFS_BASE_PRI = 8'h08;
  localparam logic [7:0]   OFS_EXT_EN   = 8'h0C;
  localparam logic [7:0]   OFS_EXT_PRI  = 8'h10;
  localparam logic [7:0]   OFS_STATUS   = 8'h14;

  // timer control, enable register and source order field positions
  localparam int           TRIG0_BIT    = 0;
  localparam int           PEND0_BIT    = 1;
  localparam int           TRIG1_BIT    = 2;
  localparam int           PEND1_BIT    = 3;
  localparam int           GLOBAL_BIT   = 7;
  localparam int           EXT_ORDER0   = 0;
  localparam int           EXT_ORDER1   = 2;
  localparam int           EXT1_BASE    = 6;
  localparam int           EXT2_BASE    = 14;

  localparam logic [7:0]   RST_BASE_EN  = 8'h00;
  localparam logic [5:0]   RST_BASE_PRI = 6'h00;
  localparam logic [1:0]   PRI_UNUSED   = 2'h3;
  localparam logic [6:0]   RST_EXT      = 7'h00;
  localparam logic [15:0]  VEC_BASE     = 16'h0003;
  localparam logic [15:0]  VEC_RESET    = 16'h0000;
  localparam int           CALL_CYCLES  = 4;
  localparam int           DETECT_CYC   = 1;

  typedef struct packed {
    logic                  req;
    logic                  high;
    logic [ORDER_W-1:0]    order;
    logic [15:0]           vector;
    logic [1:0]            page;
    logic                  page_load;
  } itvu_call_t;

  typedef struct packed {
    logic [1:0]            trig;
    logic [1:0]            pend;
    logic [1:0]            pin_low;
    logic [7:0]            base_en;
    logic [5:0]            base_pri;
    logic [6:0]            en1;
    logic [6:0]            en2;
    logic [6:0]            pri1;
    logic [6:0]            pri2;
    logic                  act_hi;
    logic                  act_lo;
    logic                  wait_one;
    itvu_call_t            call;
    logic [31:0]           prdata;
    logic                  pslverr;
  } itvu_state_t;

  function automatic logic [15:0] itvu_vector(input logic [ORDER_W-1:0] ord);
    logic [15:0] v;
    v = VEC_BASE + {8'h00, ord, 3'h0};
    if (ord == 5'h11) begin
      v = 16'h0093;
    end else if (ord == 5'h12) begin
      v = 16'h008B;
    end
    return v;
  endfunction

  function automatic logic [1:0] itvu_page(input logic [ORDER_W-1:0] ord);
    logic [1:0] p;
    p = 2'h0;
    unique case (ord)
      5'h0A, 5'h0E, 5'h13, 5'h14: p = 2'h1;
      5'h0B, 5'h10, 5'h11, 5'h12: p = 2'h2;
      5'h0C:                      p = 2'h3;
      default:                    p = 2'h0;
    endcase
    return p;
  endfunction

  function automatic logic [ORDER_W-1:0] itvu_lowest(input logic [NUM_SRC-1:0] vec);
    logic [ORDER_W-1:0] idx;
    idx = 5'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = ORDER_W'(i);
      end
    end
    return idx;
  endfunction

  // spreads base and extended bytes onto the 21 source orders
  function automatic logic [NUM_SRC-1:0] itvu_spread(input logic [5:0] base,
                                                     input logic [6:0] ext1,
                                                     input logic [6:0] ext2);
    return {ext2, 1'b0, ext1, base};
  endfunction

endpackage

// File: core/itvu_core.sv
// two-level vectored interrupt unit with apb register access
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module itvu_core (
  // clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [itvu_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // external request pins
  input  wire logic                           external_request_zero_pin_n,
  input  wire logic                           external_request_one_pin_n,
  // on-chip peripheral pending flags, by fixed order
  input  wire logic [itvu_pkg::NUM_SRC-1:0]   periph_pending,
  // instruction sequencer
  input  wire logic                           auto_page_switch_enable,
  input  wire logic                           instr_done,
  input  wire logic                           return_from_service_done,
  input  wire logic                           call_take,
  output var itvu_pkg::itvu_call_t            call
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  itvu_pkg::itvu_state_t s_ff;
  itvu_pkg::itvu_state_t nxt_s;

  logic                             wr_acc;
  logic                             rd_setup;
  logic [1:0]                       pin_low;
  logic [1:0]                       fall;
  logic [itvu_pkg::NUM_SRC-1:0]     pend_all;
  logic [itvu_pkg::NUM_SRC-1:0]     en_all;
  logic [itvu_pkg::NUM_SRC-1:0]     pri_all;
  logic [itvu_pkg::NUM_SRC-1:0]     elig;
  logic [itvu_pkg::NUM_SRC-1:0]     hi_cand;
  logic [itvu_pkg::NUM_SRC-1:0]     lo_cand;
  logic                             pick_hi;
  logic                             cand_any;
  logic [itvu_pkg::ORDER_W-1:0]     cand_ord;
  logic                             take;

  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pin_low  = {!external_request_one_pin_n, !external_request_zero_pin_n};
  assign fall     = pin_low & ~s_ff.pin_low;
  assign take     = call_take && s_ff.call.req;

  // ----------------------------------------------------------------
  // decode, every cycle
  // ----------------------------------------------------------------
  always_comb begin
    pend_all = periph_pending;
    pend_all[itvu_pkg::EXT_ORDER0] = s_ff.pend[0];
    pend_all[itvu_pkg::EXT_ORDER1] = s_ff.pend[1];
    pend_all[13] = 1'b0;
    en_all  = itvu_pkg::itvu_spread(s_ff.base_en[5:0], s_ff.en1, s_ff.en2);
    pri_all = itvu_pkg::itvu_spread(s_ff.base_pri, s_ff.pri1, s_ff.pri2);
    elig    = pend_all & en_all & {itvu_pkg::NUM_SRC{s_ff.base_en[itvu_pkg::GLOBAL_BIT]}};
    if (s_ff.wait_one || s_ff.act_hi) begin
      elig = '0;
    end
    hi_cand = elig & pri_all;
    lo_cand = (s_ff.act_lo) ? '0 : (elig & ~pri_all);
    pick_hi = |hi_cand;
    cand_any = pick_hi || (|lo_cand);
    cand_ord = itvu_pkg::itvu_lowest(pick_hi ? hi_cand : lo_cand);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.pin_low = pin_low;

    // external pending flags: software write first, hardware set wins
    if (wr_acc && paddr == itvu_pkg::OFS_TCTRL) begin
      nxt_s.trig[0] = pwdata[itvu_pkg::TRIG0_BIT];
      nxt_s.trig[1] = pwdata[itvu_pkg::TRIG1_BIT];
      nxt_s.pend[0] = pwdata[itvu_pkg::PEND0_BIT];
      nxt_s.pend[1] = pwdata[itvu_pkg::PEND1_BIT];
    end
    if (take && s_ff.call.order == itvu_pkg::EXT_ORDER0 && s_ff.trig[0]) begin
      nxt_s.pend[0] = 1'b0;
    end
    if (take && s_ff.call.order == itvu_pkg::EXT_ORDER1 && s_ff.trig[1]) begin
      nxt_s.pend[1] = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      if (s_ff.trig[i]) begin
        if (fall[i]) begin
          nxt_s.pend[i] = 1'b1;
        end
      end else begin
        nxt_s.pend[i] = pin_low[i];
      end
    end

    // other registers
    if (wr_acc) begin
      unique case (paddr)
        itvu_pkg::OFS_BASE_EN:  nxt_s.base_en = pwdata[7:0];
        itvu_pkg::OFS_BASE_PRI: nxt_s.base_pri = pwdata[5:0];
        itvu_pkg::OFS_EXT_EN: begin
          nxt_s.en1 = pwdata[6:0];
          nxt_s.en2 = pwdata[14:8];
        end
        itvu_pkg::OFS_EXT_PRI: begin
          nxt_s.pri1 = pwdata[6:0];
          nxt_s.pri2 = pwdata[14:8];
        end
        default: ;
      endcase
    end

    // in-service levels and the one-instruction hold
    if (take) begin
      if (s_ff.call.high) begin
        nxt_s.act_hi = 1'b1;
      end else begin
        nxt_s.act_lo = 1'b1;
      end
    end
    if (return_from_service_done) begin
      if (s_ff.act_hi) begin
        nxt_s.act_hi = 1'b0;
      end else begin
        nxt_s.act_lo = 1'b0;
      end
      nxt_s.wait_one = 1'b1;
    end else if (instr_done) begin
      nxt_s.wait_one = 1'b0;
    end

    // one detection cycle, then the sequencer runs the call
    nxt_s.call.req       = cand_any && !take;
    nxt_s.call.high      = pick_hi;
    nxt_s.call.order     = cand_ord;
    nxt_s.call.vector    = itvu_pkg::itvu_vector(cand_ord);
    nxt_s.call.page      = itvu_pkg::itvu_page(cand_ord);
    nxt_s.call.page_load = cand_any && !take && auto_page_switch_enable;

    // read data caught in setup so the access phase answers at once
    if (rd_setup) begin
      nxt_s.pslverr = 1'b0;
      nxt_s.prdata  = '0;
      unique case (paddr)
        itvu_pkg::OFS_TCTRL:    nxt_s.prdata[3:0] = {s_ff.pend[1], s_ff.trig[1], s_ff.pend[0], s_ff.trig[0]};
        itvu_pkg::OFS_BASE_EN:  nxt_s.prdata[7:0] = s_ff.base_en;
        itvu_pkg::OFS_BASE_PRI: nxt_s.prdata[7:0] = {itvu_pkg::PRI_UNUSED, s_ff.base_pri};
        itvu_pkg::OFS_EXT_EN:   nxt_s.prdata[14:0] = {s_ff.en2, 1'b0, s_ff.en1};
        itvu_pkg::OFS_EXT_PRI:  nxt_s.prdata[14:0] = {s_ff.pri2, 1'b0, s_ff.pri1};
        itvu_pkg::OFS_STATUS:   nxt_s.prdata[24:0] = {s_ff.call.vector, s_ff.call.order,
                                                      s_ff.wait_one, s_ff.act_lo, s_ff.act_hi, s_ff.call.req};
        default:                nxt_s.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff          <= '0;
      s_ff.base_en  <= itvu_pkg::RST_BASE_EN;
      s_ff.base_pri <= itvu_pkg::RST_BASE_PRI;
      s_ff.pri1     <= itvu_pkg::RST_EXT;
      s_ff.pri2     <= itvu_pkg::RST_EXT;
      s_ff.call.vector <= itvu_pkg::VEC_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready  = 1'b1;
  assign prdata  = s_ff.prdata;
  assign pslverr = s_ff.pslverr && psel && penable;
  assign call    = s_ff.call;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic tctrl_wr;
  assign tctrl_wr = wr_acc && paddr == itvu_pkg::OFS_TCTRL;

  sequence seq_taken_edge0;
    take && s_ff.call.order == itvu_pkg::EXT_ORDER0 && s_ff.trig[0] && !fall[0] && !tctrl_wr;
  endsequence

  sequence seq_return_hold;
    return_from_service_done ##1 s_ff.wait_one;
  endsequence

  chk_level_follows: assert property (!s_ff.trig[0] && !tctrl_wr |=> s_ff.pend[0] == $past(pin_low[0]))
    else $error("level pending flag did not follow pin");
  chk_edge_clear: assert property (seq_taken_edge0 |=> !s_ff.pend[0])
    else $error("edge pending flag not cleared on vectoring");
  chk_edge_latch: assert property (s_ff.trig[1] && fall[1] |=> s_ff.pend[1])
    else $error("falling edge not latched");
  chk_global_gate: assert property (!s_ff.base_en[itvu_pkg::GLOBAL_BIT] |=> !s_ff.call.req)
    else $error("request raised with global enable off");
  chk_high_blocks: assert property (s_ff.act_hi |=> !s_ff.call.req)
    else $error("request raised during high level routine");
  chk_low_preempt: assert property (s_ff.act_lo |=> !s_ff.call.req || s_ff.call.high)
    else $error("low request preempted low routine");
  chk_return_hold: assert property (seq_return_hold |=> !s_ff.call.req)
    else $error("call made before one instruction after return");
  chk_detect_one: assert property (cand_any && !take |=> s_ff.call.req && s_ff.call.order == $past(cand_ord)
                                   && s_ff.call.vector == itvu_pkg::itvu_vector($past(cand_ord)))
    else $error("detected request not presented one cycle later");
  chk_high_first: assert property (s_ff.call.req && !s_ff.call.high |-> $past(hi_cand) == '0)
    else $error("low request chosen over high");
  chk_ext0_vector: assert property (s_ff.call.req && s_ff.call.order == 5'h00 |-> s_ff.call.vector == 16'h0003)
    else $error("wrong vector for pin zero");

endmodule
`default_nettype wire

// File: tb/itvu_source_model.sv
// far-side model: external request pins driven as active-low sources
`timescale 1ns/1ps
`default_nettype none
module itvu_source_model (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // stimulus from the bench
  input  wire logic [1:0]           fire,
  input  wire logic [1:0]           edge_mode,
  // sequencer view
  input  wire logic                 call_take,
  input  wire itvu_pkg::itvu_call_t call,
  // pins
  output logic                      pin0_n,
  output logic                      pin1_n
);
  logic [1:0] low_ff;
  // level source holds low until its call is taken, then lets go before return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_ff <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (fire[i]) begin
          low_ff[i] <= 1'b1;
        end else if (edge_mode[i] || (call_take && call.req && call.order == 5'(2 * i))) begin
          low_ff[i] <= 1'b0;
        end
      end
    end
  end
  assign pin0_n = ~low_ff[0];
  assign pin1_n = ~low_ff[1];
endmodule
`default_nettype wire

// File: tb/tb_itvu_core.sv
// self-checking bench of the two-level vectored interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_itvu_core;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pin0_n, pin1_n;
  logic [20:0] periph = 21'h0;
  logic auto_pg = 1'b0, instr_done = 1'b0, return_from_service_done = 1'b0, call_take = 1'b0;
  logic [1:0] fire = 2'h0, edge_mode = 2'h0;
  itvu_pkg::itvu_call_t call;
  int err_total = 0, checks_done = 0;
  always #20 pclk = ~pclk;
  itvu_core u_itvu_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_request_zero_pin_n(pin0_n), .external_request_one_pin_n(pin1_n), .periph_pending(periph),
    .auto_page_switch_enable(auto_pg), .instr_done(instr_done), .return_from_service_done(return_from_service_done),
    .call_take(call_take), .call(call));
  itvu_source_model u_itvu_source_model (.pclk(pclk), .presetn(presetn), .fire(fire), .edge_mode(edge_mode),
    .call_take(call_take), .call(call), .pin0_n(pin0_n), .pin1_n(pin1_n));
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic er);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic er;
    apb(1'b1, a, d, q, er);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic er;
    apb(1'b0, a, 32'h0, q, er);
    chk(n, q, e);
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // 0 take, 1 return, 2 instruction, 3 pin zero, 4 pin one
  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      0: call_take <= 1'b1;
      1: return_from_service_done <= 1'b1;
      2: instr_done <= 1'b1;
      default: fire <= (k == 3) ? 2'h1 : 2'h2;
    endcase
    @(posedge pclk);
    call_take <= 1'b0; return_from_service_done <= 1'b0; instr_done <= 1'b0; fire <= 2'h0;
  endtask
  task automatic wait_req(input string n, input logic [4:0] ord, input logic [15:0] vec, input logic hi);
    int k;
    k = 0;
    #1;
    while (call.req !== 1'b1 && k < 40) begin
      clk(1);
      k++;
    end
    chk({n, " req"}, 32'(call.req), 32'h1);
    chk({n, " order"}, 32'(call.order), 32'(ord));
    chk({n, " vector"}, 32'(call.vector), 32'(vec));
    chk({n, " level"}, 32'(call.high), 32'(hi));
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic er;
    rd("pri reset", itvu_pkg::OFS_BASE_PRI, 32'h000000C0);
    rd("tctrl reset", itvu_pkg::OFS_TCTRL, 32'h00000000);
    apb(1'b0, 8'h18, 32'h0, q, er);
    chk("unmapped err", 32'(er), 32'h1);
    chk("unmapped data", q, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_edge();
    wr(itvu_pkg::OFS_TCTRL, 32'h1);
    edge_mode <= 2'h1;
    wr(itvu_pkg::OFS_BASE_EN, 32'h80);
    pulse(3);
    clk(4);
    chk("no req disabled", 32'(call.req), 32'h0);
    rd("pend while off", itvu_pkg::OFS_TCTRL, 32'h3);
    wr(itvu_pkg::OFS_TCTRL, 32'h1);
    wr(itvu_pkg::OFS_BASE_EN, 32'h81);
    pulse(3);
    clk(1);
    chk("latency early", 32'(call.req), 32'h0);
    clk(1);
    chk("latency", 32'(call.req), 32'h1);
    wait_req("edge0", 5'h00, 16'h0003, 1'b0);
    rd("status edge0", itvu_pkg::OFS_STATUS, 32'h00000601);
    pulse(0);
    clk(2);
    chk("req after take", 32'(call.req), 32'h0);
    rd("pend cleared", itvu_pkg::OFS_TCTRL, 32'h1);
    pulse(1);
    pulse(2);
    edge_mode <= 2'h0;
    $display("test edge done");
  endtask
  task automatic t_nest();
    wr(itvu_pkg::OFS_TCTRL, 32'h0);
    wr(itvu_pkg::OFS_BASE_PRI, 32'h14);
    wr(itvu_pkg::OFS_BASE_EN, 32'h96);
    periph[1] <= 1'b1;
    wait_req("timer0", 5'h01, 16'h000B, 1'b0);
    pulse(0);
    periph[1] <= 1'b0;
    pulse(4);
    wait_req("preempt", 5'h02, 16'h0013, 1'b1);
    rd("level pend", itvu_pkg::OFS_TCTRL, 32'h8);
    pulse(0);
    periph[4] <= 1'b1;
    clk(4);
    rd("pend follows pin", itvu_pkg::OFS_TCTRL, 32'h0);
    chk("no preempt high", 32'(call.req), 32'h0);
    pulse(1);
    clk(3);
    chk("wait one instr", 32'(call.req), 32'h0);
    pulse(2);
    wait_req("after return", 5'h04, 16'h0023, 1'b1);
    pulse(0);
    periph[4] <= 1'b0;
    pulse(1);
    pulse(2);
    pulse(1);
    pulse(2);
    $display("test nest done");
  endtask
  task automatic t_arb();
    wr(itvu_pkg::OFS_BASE_PRI, 32'h10);
    wr(itvu_pkg::OFS_BASE_EN, 32'h92);
    periph[1] <= 1'b1;
    periph[4] <= 1'b1;
    wait_req("high first", 5'h04, 16'h0023, 1'b1);
    wr(itvu_pkg::OFS_BASE_PRI, 32'h00);
    clk(3);
    wait_req("fixed order", 5'h01, 16'h000B, 1'b0);
    periph <= 21'h0;
    auto_pg <= 1'b1;
    wr(itvu_pkg::OFS_BASE_EN, 32'h80);
    wr(itvu_pkg::OFS_EXT_EN, 32'h840);
    periph[12] <= 1'b1;
    periph[17] <= 1'b1;
    clk(3);
    wait_req("cmp2", 5'h0C, 16'h0063, 1'b0);
    chk("page cmp2", 32'({call.page_load, call.page}), 32'h7);
    periph[12] <= 1'b0;
    clk(3);
    wait_req("adc2", 5'h11, 16'h0093, 1'b0);
    chk("page adc2", 32'(call.page), 32'h2);
    periph <= 21'h0;
    $display("test arb done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_edge();
    t_nest();
    t_arb();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
